// ---- core/srlt_pkg.sv ----
// Constants for the single-rate read latency table: bands, commands and cycle counts.
// Assumes both ends of the link use these names and the same core_clk.
// What this block does
// - All-ones byte marks command unsupported in band.
// - Band 90 MHz: code 01b, limit 5Ah.
// - Band 104 MHz: code 10b, limit 68h.
// - Band 133 MHz: code 10b, limit 85h.
// - Plain read unsupported at 80/90/104/133 MHz.
// - Fast, dual-out, quad-out reads: zero mode cycles.
// - Fast read: eight dummy cycles, all bands.
// - Dual-out: eight dummies, unsupported at 133 MHz.
// - Quad-out: eight dummies, unsupported at 133 MHz.
// - Dual I/O: four mode cycles, not 133.
// - Dual I/O dummies: 0, 1, 2 by band.
// - Quad I/O: two mode cycles, not 133.
// - Quad I/O dummies: 4, 4, 5 by band.
// - Band 80 MHz selected by code 00b.
package srlt_pkg;

  typedef enum logic [2:0] {
    SRLT_CMD_READ,
    SRLT_CMD_FAST,
    SRLT_CMD_DUAL_OUT,
    SRLT_CMD_QUAD_OUT,
    SRLT_CMD_DUAL_IO,
    SRLT_CMD_QUAD_IO
  } srlt_cmd_e;

  localparam int SRLT_NUM_BANDS = 4;
  localparam int SRLT_NUM_CMDS = 6;

  localparam logic [7:0] SRLT_UNSUPPORTED = 8'hFF;

  localparam logic [1:0] SRLT_CODE_80 = 2'h0;
  localparam logic [1:0] SRLT_CODE_90 = 2'h1;
  localparam logic [1:0] SRLT_CODE_104 = 2'h2;
  localparam logic [1:0] SRLT_CODE_133 = 2'h2;

  localparam logic [7:0] SRLT_LIMIT_80 = 8'h50;
  localparam logic [7:0] SRLT_LIMIT_90 = 8'h5A;
  localparam logic [7:0] SRLT_LIMIT_104 = 8'h68;
  localparam logic [7:0] SRLT_LIMIT_133 = 8'h85;

  // Band index 3 is the 133 MHz band; it shares code 10b with the 104 MHz band.
  localparam logic [1:0] SRLT_BAND_80 = 2'h0;
  localparam logic [1:0] SRLT_BAND_90 = 2'h1;
  localparam logic [1:0] SRLT_BAND_104 = 2'h2;
  localparam logic [1:0] SRLT_BAND_133 = 2'h3;

  localparam logic [7:0] SRLT_MODE_ZERO = 8'h00;
  localparam logic [7:0] SRLT_DUMMY_OUT = 8'h08;
  localparam logic [7:0] SRLT_MODE_DUAL_IO = 8'h04;
  localparam logic [7:0] SRLT_MODE_QUAD_IO = 8'h02;
  localparam logic [7:0] SRLT_DUMMY_DUAL_IO_80 = 8'h00;
  localparam logic [7:0] SRLT_DUMMY_DUAL_IO_90 = 8'h01;
  localparam logic [7:0] SRLT_DUMMY_DUAL_IO_104 = 8'h02;
  localparam logic [7:0] SRLT_DUMMY_QUAD_IO_80 = 8'h04;
  localparam logic [7:0] SRLT_DUMMY_QUAD_IO_90 = 8'h04;
  localparam logic [7:0] SRLT_DUMMY_QUAD_IO_104 = 8'h05;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dummy;
  } srlt_entry_s;

endpackage : srlt_pkg

// ---- core/srlt_if.sv ----
// Link between the host controller and the device latency table.
// Assumes one shared core_clk and reset.
`timescale 1ns/1ps
interface srlt_if (
  input wire logic core_clk,
  input wire logic reset
);
  logic req;
  srlt_pkg::srlt_cmd_e cmd;
  logic [7:0] freq_limit;
  logic [1:0] latency_code;
  logic ack;
  logic [7:0] mode_cycles;
  logic [7:0] dummy_cycles;
  logic supported;

  modport device (
    input core_clk,
    input reset,
    input req,
    input cmd,
    input freq_limit,
    input latency_code,
    output ack,
    output mode_cycles,
    output dummy_cycles,
    output supported
  );

  modport host (
    input core_clk,
    input reset,
    output req,
    output cmd,
    output freq_limit,
    output latency_code,
    input ack,
    input mode_cycles,
    input dummy_cycles,
    input supported
  );
endinterface : srlt_if

// ---- core/srlt_device.sv ----
// Device end: looks up mode and dummy cycle counts for a single-rate read.
// Assumes the host holds cmd, code and limit steady while req is high.
`timescale 1ns/1ps
module srlt_device (
  srlt_if.device lnk,
  output logic [1:0] band
);

  // The band is resolved from the code plus the frequency limit, since code 10b
  // alone cannot tell 104 MHz from 133 MHz.
  function automatic logic [1:0] srlt_band(input logic [1:0] code, input logic [7:0] limit);
    logic [1:0] b;
    b = srlt_pkg::SRLT_BAND_80;
    if (code == srlt_pkg::SRLT_CODE_90) begin
      b = srlt_pkg::SRLT_BAND_90;
    end else if (code == srlt_pkg::SRLT_CODE_133 && limit > srlt_pkg::SRLT_LIMIT_104) begin
      b = srlt_pkg::SRLT_BAND_133;
    end else if (code == srlt_pkg::SRLT_CODE_104) begin
      b = srlt_pkg::SRLT_BAND_104;
    end
    return b;
  endfunction : srlt_band

  function automatic srlt_pkg::srlt_entry_s srlt_lookup(input srlt_pkg::srlt_cmd_e c,
                                                       input logic [1:0] b);
    srlt_pkg::srlt_entry_s e;
    e.mode = srlt_pkg::SRLT_UNSUPPORTED;
    e.dummy = srlt_pkg::SRLT_UNSUPPORTED;
    case (c)
      srlt_pkg::SRLT_CMD_FAST: begin
        e.mode = srlt_pkg::SRLT_MODE_ZERO;
        e.dummy = srlt_pkg::SRLT_DUMMY_OUT;
      end
      srlt_pkg::SRLT_CMD_DUAL_OUT, srlt_pkg::SRLT_CMD_QUAD_OUT: begin
        if (b != srlt_pkg::SRLT_BAND_133) begin
          e.mode = srlt_pkg::SRLT_MODE_ZERO;
          e.dummy = srlt_pkg::SRLT_DUMMY_OUT;
        end
      end
      srlt_pkg::SRLT_CMD_DUAL_IO: begin
        if (b != srlt_pkg::SRLT_BAND_133) begin
          e.mode = srlt_pkg::SRLT_MODE_DUAL_IO;
          e.dummy = (b == srlt_pkg::SRLT_BAND_80) ? srlt_pkg::SRLT_DUMMY_DUAL_IO_80 :
                    (b == srlt_pkg::SRLT_BAND_90) ? srlt_pkg::SRLT_DUMMY_DUAL_IO_90 :
                    srlt_pkg::SRLT_DUMMY_DUAL_IO_104;
        end
      end
      srlt_pkg::SRLT_CMD_QUAD_IO: begin
        if (b != srlt_pkg::SRLT_BAND_133) begin
          e.mode = srlt_pkg::SRLT_MODE_QUAD_IO;
          e.dummy = (b == srlt_pkg::SRLT_BAND_80) ? srlt_pkg::SRLT_DUMMY_QUAD_IO_80 :
                    (b == srlt_pkg::SRLT_BAND_90) ? srlt_pkg::SRLT_DUMMY_QUAD_IO_90 :
                    srlt_pkg::SRLT_DUMMY_QUAD_IO_104;
        end
      end
      default: begin
        // Plain read stays all-ones in every band this table covers.
        e.mode = srlt_pkg::SRLT_UNSUPPORTED;
        e.dummy = srlt_pkg::SRLT_UNSUPPORTED;
      end
    endcase
    return e;
  endfunction : srlt_lookup

  srlt_pkg::srlt_entry_s ent_q;
  srlt_pkg::srlt_entry_s ent_d;
  logic ack_q;
  logic ack_d;
  logic [1:0] band_q;
  logic [1:0] band_d;

  always_comb begin
    band_d = band_q;
    ent_d = ent_q;
    ack_d = 1'b0;
    if (lnk.req) begin
      band_d = srlt_band(lnk.latency_code, lnk.freq_limit);
      ent_d = srlt_lookup(lnk.cmd, band_d);
      ack_d = 1'b1;
    end
  end

  always_ff @(posedge lnk.core_clk or posedge lnk.reset) begin
    if (lnk.reset) begin
      ent_q <= '{mode: srlt_pkg::SRLT_UNSUPPORTED, dummy: srlt_pkg::SRLT_UNSUPPORTED};
      ack_q <= 1'b0;
      band_q <= srlt_pkg::SRLT_BAND_80;
    end else begin
      ent_q <= ent_d;
      ack_q <= ack_d;
      band_q <= band_d;
    end
  end

  assign lnk.ack = ack_q;
  assign lnk.mode_cycles = ent_q.mode;
  assign lnk.dummy_cycles = ent_q.dummy;
  assign lnk.supported = (ent_q.mode != srlt_pkg::SRLT_UNSUPPORTED)
                         && (ent_q.dummy != srlt_pkg::SRLT_UNSUPPORTED);
  assign band = band_q;

endmodule : srlt_device

// ---- core/srlt_host.sv ----
// Host end: picks the band for its clock rate and asks for a read's cycle counts.
// Assumes the device answers one cycle after each request.
`timescale 1ns/1ps
module srlt_host (
  srlt_if.host lnk,
  input logic start,
  input srlt_pkg::srlt_cmd_e cmd,
  input logic [7:0] sck_mhz,
  output logic busy,
  output logic done,
  output logic rejected,
  output logic [7:0] mode_cycles,
  output logic [7:0] dummy_cycles
);

  typedef enum logic [1:0] {SRLT_IDLE, SRLT_WAIT} srlt_hstate_e;

  srlt_hstate_e st_q;
  srlt_hstate_e st_d;
  srlt_pkg::srlt_cmd_e cmd_q;
  srlt_pkg::srlt_cmd_e cmd_d;
  logic [1:0] code_q;
  logic [1:0] code_d;
  logic [7:0] lim_q;
  logic [7:0] lim_d;
  logic done_q;
  logic done_d;
  logic rej_q;
  logic rej_d;
  logic [7:0] mode_q;
  logic [7:0] mode_d;
  logic [7:0] dummy_q;
  logic [7:0] dummy_d;

  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    code_d = code_q;
    lim_d = lim_q;
    done_d = 1'b0;
    rej_d = 1'b0;
    mode_d = mode_q;
    dummy_d = dummy_q;
    case (st_q)
      SRLT_IDLE: begin
        if (start) begin
          // Lowest band whose limit is not below the clock rate, else the 133 MHz band.
          if (sck_mhz <= srlt_pkg::SRLT_LIMIT_80) begin
            code_d = srlt_pkg::SRLT_CODE_80;
            lim_d = srlt_pkg::SRLT_LIMIT_80;
          end else if (sck_mhz <= srlt_pkg::SRLT_LIMIT_90) begin
            code_d = srlt_pkg::SRLT_CODE_90;
            lim_d = srlt_pkg::SRLT_LIMIT_90;
          end else if (sck_mhz <= srlt_pkg::SRLT_LIMIT_104) begin
            code_d = srlt_pkg::SRLT_CODE_104;
            lim_d = srlt_pkg::SRLT_LIMIT_104;
          end else begin
            code_d = srlt_pkg::SRLT_CODE_133;
            lim_d = srlt_pkg::SRLT_LIMIT_133;
          end
          cmd_d = cmd;
          st_d = SRLT_WAIT;
        end
      end
      default: begin
        if (lnk.ack) begin
          st_d = SRLT_IDLE;
          // A command the device marks all-ones ends with rejected set instead of done.
          if (!lnk.supported) begin
            rej_d = 1'b1;
          end else begin
            done_d = 1'b1;
            mode_d = lnk.mode_cycles;
            dummy_d = lnk.dummy_cycles;
          end
        end
      end
    endcase
  end

  always_ff @(posedge lnk.core_clk or posedge lnk.reset) begin
    if (lnk.reset) begin
      st_q <= SRLT_IDLE;
      cmd_q <= srlt_pkg::SRLT_CMD_READ;
      code_q <= srlt_pkg::SRLT_CODE_80;
      lim_q <= srlt_pkg::SRLT_LIMIT_80;
      done_q <= 1'b0;
      rej_q <= 1'b0;
      mode_q <= 8'h00;
      dummy_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      code_q <= code_d;
      lim_q <= lim_d;
      done_q <= done_d;
      rej_q <= rej_d;
      mode_q <= mode_d;
      dummy_q <= dummy_d;
    end
  end

  // The request is held for one cycle; the device answers on the next edge.
  assign lnk.req = (st_q == SRLT_WAIT) && !lnk.ack;
  assign lnk.cmd = cmd_q;
  assign lnk.latency_code = code_q;
  assign lnk.freq_limit = lim_q;
  assign busy = (st_q != SRLT_IDLE);
  assign done = done_q;
  assign rejected = rej_q;
  assign mode_cycles = mode_q;
  assign dummy_cycles = dummy_q;

endmodule : srlt_host

// ---- verification/srlt_chk.sv ----
// Checker on the link between the host and device ends of the latency table.
// Assumes it is instantiated beside the interface and sees its signals.
`timescale 1ns/1ps
module srlt_chk (
  input logic core_clk,
  input logic reset,
  input logic req,
  input srlt_pkg::srlt_cmd_e cmd,
  input logic [7:0] freq_limit,
  input logic [1:0] latency_code,
  input logic ack,
  input logic [7:0] mode_cycles,
  input logic [7:0] dummy_cycles,
  input logic supported
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  a_ack_follows_req: assert property (req |=> ack)
    else $error("ack missing after request");
  a_ack_has_cause: assert property (ack |-> $past(req) && !req)
    else $error("ack without request");
  a_flag_matches: assert property (supported == (&mode_cycles == 0 && &dummy_cycles == 0))
    else $error("supported flag wrong");
  a_code_by_limit: assert property (req |->
    (freq_limit == 8'h50 && latency_code == 2'h0) ||
    (freq_limit == 8'h5A && latency_code == 2'h1) ||
    (freq_limit == 8'h68 && latency_code == 2'h2) ||
    (freq_limit == 8'h85 && latency_code == 2'h2)) else $error("code and limit disagree");
  a_plain_read: assert property (ack && $past(cmd) == srlt_pkg::SRLT_CMD_READ |->
    !supported) else $error("plain read supported");
  a_fast_read: assert property (ack && $past(cmd) == srlt_pkg::SRLT_CMD_FAST |->
    mode_cycles == 8'h00 && dummy_cycles == 8'h08) else $error("fast read counts wrong");
  a_out_reads: assert property (ack && ($past(cmd) == srlt_pkg::SRLT_CMD_DUAL_OUT
    || $past(cmd) == srlt_pkg::SRLT_CMD_QUAD_OUT) |-> ($past(freq_limit) == 8'h85) ?
    !supported : mode_cycles == 8'h00 && dummy_cycles == 8'h08)
    else $error("output read counts wrong");
  a_dual_io: assert property (ack && $past(cmd) == srlt_pkg::SRLT_CMD_DUAL_IO |->
    ($past(freq_limit) == 8'h85) ? !supported : mode_cycles == 8'h04 && dummy_cycles ==
    ($past(freq_limit) == 8'h50 ? 8'h00 : $past(freq_limit) == 8'h5A ? 8'h01 : 8'h02))
    else $error("dual io counts wrong");
  a_quad_io: assert property (ack && $past(cmd) == srlt_pkg::SRLT_CMD_QUAD_IO |->
    ($past(freq_limit) == 8'h85) ? !supported : mode_cycles == 8'h02 && dummy_cycles ==
    ($past(freq_limit) == 8'h68 ? 8'h05 : 8'h04)) else $error("quad io counts wrong");
  a_counts_hold: assert property (!ack |-> $stable(mode_cycles) && $stable(dummy_cycles))
    else $error("counts changed without answer");
endmodule : srlt_chk

// ---- verification/test_sdr_read_latency_table.sv ----
// Self-checking bench: host and device ends joined by the link interface.
// Assumes one free-running core_clk and one asynchronous reset for both ends.
`timescale 1ns/1ps
module test_sdr_read_latency_table;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  srlt_pkg::srlt_cmd_e cmd = srlt_pkg::SRLT_CMD_READ;
  logic [7:0] sck_mhz = 8'h50;
  logic busy, done, rejected;
  logic [7:0] mode_cycles, dummy_cycles;
  logic [1:0] band;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] fl [8] = '{8'h01, 8'h50, 8'h51, 8'h5A, 8'h5B, 8'h68, 8'h69, 8'h85};
  logic [7:0] lim [4] = '{8'h50, 8'h5A, 8'h68, 8'h85};

  srlt_if lnk (.core_clk(core_clk), .reset(reset));
  srlt_device srlt_device_i (.lnk(lnk), .band(band));
  srlt_host srlt_host_i (.lnk(lnk), .start(start), .cmd(cmd), .sck_mhz(sck_mhz), .busy(busy),
    .done(done), .rejected(rejected), .mode_cycles(mode_cycles), .dummy_cycles(dummy_cycles));
  srlt_chk srlt_chk_i (.core_clk(core_clk), .reset(reset), .req(lnk.req), .cmd(lnk.cmd),
    .freq_limit(lnk.freq_limit), .latency_code(lnk.latency_code), .ack(lnk.ack),
    .mode_cycles(lnk.mode_cycles), .dummy_cycles(lnk.dummy_cycles), .supported(lnk.supported));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // The hang guard allows far more than the roughly 360 cycles the run needs.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  function automatic srlt_pkg::srlt_entry_s exp_entry(srlt_pkg::srlt_cmd_e c, int b);
    srlt_pkg::srlt_entry_s e;
    e = '{8'hFF, 8'hFF};
    case (c)
      srlt_pkg::SRLT_CMD_FAST: e = '{8'h00, 8'h08};
      srlt_pkg::SRLT_CMD_DUAL_OUT, srlt_pkg::SRLT_CMD_QUAD_OUT: if (b < 3) e = '{8'h00, 8'h08};
      srlt_pkg::SRLT_CMD_DUAL_IO: if (b < 3) e = '{8'h04, 8'(b)};
      srlt_pkg::SRLT_CMD_QUAD_IO: if (b < 3) e = '{8'h02, (b == 2) ? 8'h05 : 8'h04};
      default: ;
    endcase
    return e;
  endfunction : exp_entry

  task automatic run(srlt_pkg::srlt_cmd_e c, logic [7:0] f);
    int b;
    srlt_pkg::srlt_entry_s e;
    logic ok;
    b = f <= 8'h50 ? 0 : f <= 8'h5A ? 1 : f <= 8'h68 ? 2 : 3;
    e = exp_entry(c, b);
    ok = e.mode != 8'hFF;
    @(posedge core_clk);
    start <= 1'b1;
    cmd <= c;
    sck_mhz <= f;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    chk_bit("busy", 1'b1, busy);
    repeat (5) begin
      @(posedge core_clk);
      #1;
      if (done === 1'b1 || rejected === 1'b1) break;
    end
    chk_bit("idle", 1'b0, busy);
    chk_bit("done", ok, done);
    chk_bit("rejected", !ok, rejected);
    chk_bit("supported", ok, lnk.supported);
    chk_byte("band", 8'(b), {6'h00, band});
    chk_byte("limit", lim[b], lnk.freq_limit);
    chk_byte("code", 8'((b > 2) ? 2 : b), {6'h00, lnk.latency_code});
    chk_byte("link mode", e.mode, lnk.mode_cycles);
    chk_byte("link dummy", e.dummy, lnk.dummy_cycles);
    if (ok) begin
      chk_byte("host mode", e.mode, mode_cycles);
      chk_byte("host dummy", e.dummy, dummy_cycles);
    end
  endtask : run

  initial begin
    void'($urandom(47));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      foreach (fl[i]) run(srlt_pkg::srlt_cmd_e'(c), fl[i]);
    end
    @(posedge core_clk);
    reset <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_byte("reset mode", 8'hFF, lnk.mode_cycles);
    chk_bit("reset supported", 1'b0, lnk.supported);
    chk_byte("reset dummy", 8'hFF, lnk.dummy_cycles);
    chk_bit("reset busy", 1'b0, busy);
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (40) run(srlt_pkg::srlt_cmd_e'($urandom % 6), 8'($urandom_range(133, 1)));
    give_verdict();
  end
endmodule : test_sdr_read_latency_table
